// ### logic/fpsk_top.v
// Front panel display latches, key scan, rear requests, knob, blanking and refresh tick over APB
//
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "fpsk_map.vh"
module fpsk_top #(
    parameter REFRESH_CYC     = `FPSK_REFRESH_CYC,
    parameter REFRESH_OFF_CYC = `FPSK_REFRESH_OFF_CYC,
    parameter BLANK_CYC       = `FPSK_BLANK_CYC
) (
    input  wire        mclk_i,
    input  wire        arst_n_i,
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [7:0]  paddr_i,
    input  wire [31:0] pwdata_i,
    output reg  [31:0] prdata_o,
    output wire        pready_o,
    output wire        pslverr_o,
    input  wire        knob_gate_phase_n_i,
    input  wire        knob_step_phase_n_i,
    output wire        turn_irq_n_o,
    output wire        turn_direction_up_o,
    input  wire [7:0]  key_row_n_i,
    output wire [7:0]  key_col_o,
    output wire [7:0]  key_col_oe_n_o,
    input  wire        seq_up_n_i,
    input  wire        seq_down_n_i,
    input  wire        bright_sel_n_i,
    input  wire        clear_local_key_n_i,
    input  wire        standby_sw_closed_i,
    output wire        standby_o,
    output wire        standby_led_o,
    output wire [8:0]  grid_o,
    output wire [7:0]  anode_a_o,
    output wire [7:0]  anode_b_o,
    output wire [7:0]  anode_c_o,
    output wire [7:0]  anode_d_o,
    output wire        grid_latch_sel_a_n_o,
    output wire        grid_latch_sel_b_n_o,
    output wire        anode_latch_sel_a_n_o,
    output wire        anode_latch_sel_b_n_o,
    output wire        anode_latch_sel_c_n_o,
    output wire        anode_latch_sel_d_n_o,
    output wire        blank_o,
    output wire        refresh_irq_n_o,
    output wire        refresh_rst_o
);
    localparam [23:0] REFRESH_LAST     = REFRESH_CYC - 1;
    localparam [23:0] REFRESH_OFF_LAST = REFRESH_OFF_CYC - 1;
    localparam [23:0] BLANK_LAST       = BLANK_CYC - 1;

    // Refresh tick sequencer states
    localparam [2:0] TK_COUNT = 3'b001;
    localparam [2:0] TK_IRQ   = 3'b010;
    localparam [2:0] TK_RST   = 3'b100;

    reg  [7:0]  grid_a_ff;
    reg         grid_b_ff;
    reg  [7:0]  anode_a_ff;
    reg  [7:0]  anode_b_ff;
    reg  [7:0]  anode_c_ff;
    reg  [7:0]  anode_d_ff;
    reg  [5:0]  sel_n_ff;
    reg  [5:0]  nxt_sel_n;
    reg         disp_on_ff;
    reg         clear_lvl_ff;
    reg         clear_lvl_d_ff;
    reg  [23:0] blank_cnt_ff;
    reg         blank_ff;
    reg  [23:0] tick_cnt_ff;
    reg  [2:0]  tick_st_ff;
    reg  [31:0] nxt_rdata;
    reg         dec_hit;

    wire        wr_en;
    wire        rd_en;
    wire        latch_wr;
    wire        live;
    wire        scan;
    wire [7:0]  row_n;
    wire [4:0]  stat_n;
    wire [1:0]  knob_n;
    wire [2:0]  req;
    wire        clr_key;
    wire [23:0] tick_last;
    wire        knob_clear;

    // Asynchronous pins pass two flip-flops first
    fpsk_sync #(
        .W   (8),
        .RST (1'b1)
    ) u_row_sync (
        .mclk_i   (mclk_i),
        .arst_n_i (arst_n_i),
        .async_i  (key_row_n_i),
        .sync_o   (row_n)
    );

    fpsk_sync #(
        .W   (5),
        .RST (1'b1)
    ) u_stat_sync (
        .mclk_i   (mclk_i),
        .arst_n_i (arst_n_i),
        .async_i  ({seq_up_n_i, seq_down_n_i, bright_sel_n_i, clear_local_key_n_i, ~standby_sw_closed_i}),
        .sync_o   (stat_n)
    );

    fpsk_sync #(
        .W   (2),
        .RST (1'b1)
    ) u_knob_sync (
        .mclk_i   (mclk_i),
        .arst_n_i (arst_n_i),
        .async_i  ({knob_gate_phase_n_i, knob_step_phase_n_i}),
        .sync_o   (knob_n)
    );

    fpsk_knob u_knob (
        .mclk_i              (mclk_i),
        .arst_n_i            (arst_n_i),
        .gate_n_i            (knob_n[1]),
        .step_n_i            (knob_n[0]),
        .clear_i             (knob_clear),
        .turn_irq_n_o        (turn_irq_n_o),
        .turn_direction_up_o (turn_direction_up_o)
    );

    // APB slave with no wait states
    assign pready_o = 1'b1;
    assign wr_en    = psel_i & penable_i & pwrite_i;
    assign rd_en    = psel_i & penable_i & ~pwrite_i;

    always @*
    begin
        dec_hit = 1'b1;
        if (paddr_i == `FPSK_OFS_GRID_A)
            dec_hit = 1'b1;
        else if (paddr_i == `FPSK_OFS_GRID_B)
            dec_hit = 1'b1;
        else if (paddr_i == `FPSK_OFS_ANODE_A)
            dec_hit = 1'b1;
        else if (paddr_i == `FPSK_OFS_ANODE_B)
            dec_hit = 1'b1;
        else if (paddr_i == `FPSK_OFS_ANODE_C)
            dec_hit = 1'b1;
        else if (paddr_i == `FPSK_OFS_ANODE_D)
            dec_hit = 1'b1;
        else if (paddr_i == `FPSK_OFS_CTRL)
            dec_hit = 1'b1;
        else if (paddr_i == `FPSK_OFS_STATUS)
            dec_hit = 1'b1;
        else if (paddr_i == `FPSK_OFS_KEYS)
            dec_hit = 1'b1;
        else
            dec_hit = 1'b0;
    end

    assign pslverr_o = psel_i & penable_i & ~dec_hit;

    // Exactly one latch select per written byte [R14]
    always @*
    begin
        nxt_sel_n = 6'h3f;
        if (wr_en)
        begin
            if (paddr_i == `FPSK_OFS_GRID_A)
                nxt_sel_n = 6'h3e;
            else if (paddr_i == `FPSK_OFS_GRID_B)
                nxt_sel_n = 6'h3d;
            else if (paddr_i == `FPSK_OFS_ANODE_A)
                nxt_sel_n = 6'h3b;
            else if (paddr_i == `FPSK_OFS_ANODE_B)
                nxt_sel_n = 6'h37;
            else if (paddr_i == `FPSK_OFS_ANODE_C)
                nxt_sel_n = 6'h2f;
            else if (paddr_i == `FPSK_OFS_ANODE_D)
                nxt_sel_n = 6'h1f;
        end
    end

    assign latch_wr = ~&nxt_sel_n;

    // Byte-wide latches and a one-bit grid B latch; only the low byte of the bus is used [R13] [R10] [R11]
    always @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            grid_a_ff      <= 8'h00;
            grid_b_ff      <= 1'b0;
            anode_a_ff     <= 8'h00;
            anode_b_ff     <= 8'h00;
            anode_c_ff     <= 8'h00;
            anode_d_ff     <= 8'h00;
            sel_n_ff       <= 6'h3f;
            disp_on_ff     <= `FPSK_CTRL_RESET;
            clear_lvl_ff   <= 1'b0;
            clear_lvl_d_ff <= 1'b0;
        end
        else
        begin
            sel_n_ff       <= nxt_sel_n;
            clear_lvl_d_ff <= clear_lvl_ff;
            if (!nxt_sel_n[0])
                grid_a_ff <= pwdata_i[7:0];
            if (!nxt_sel_n[1])
                grid_b_ff <= pwdata_i[0];
            if (!nxt_sel_n[2])
                anode_a_ff <= pwdata_i[7:0];
            if (!nxt_sel_n[3])
                anode_b_ff <= pwdata_i[7:0];
            if (!nxt_sel_n[4])
                anode_c_ff <= pwdata_i[7:0];
            if (!nxt_sel_n[5])
                anode_d_ff <= pwdata_i[7:0];
            if (wr_en && paddr_i == `FPSK_OFS_CTRL)
            begin
                disp_on_ff   <= pwdata_i[`FPSK_CTRL_DISP_ON];
                clear_lvl_ff <= pwdata_i[`FPSK_CTRL_CLEAR];
            end
        end
    end

    // Any change of the clear level releases the knob request [R4]
    assign knob_clear = clear_lvl_ff ^ clear_lvl_d_ff;

    assign grid_latch_sel_a_n_o  = sel_n_ff[0];
    assign grid_latch_sel_b_n_o  = sel_n_ff[1];
    assign anode_latch_sel_a_n_o = sel_n_ff[2];
    assign anode_latch_sel_b_n_o = sel_n_ff[3];
    assign anode_latch_sel_c_n_o = sel_n_ff[4];
    assign anode_latch_sel_d_n_o = sel_n_ff[5];

    // Watchdog retriggered by every field or segment write [R6]
    always @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            blank_cnt_ff <= 24'h000000;
            blank_ff     <= 1'b1;
        end
        else if (latch_wr)
        begin
            blank_cnt_ff <= 24'h000000;
            blank_ff     <= 1'b0;
        end
        else if (blank_cnt_ff == BLANK_LAST)
        begin
            blank_ff <= 1'b1; // [R6]
        end
        else
        begin
            blank_cnt_ff <= blank_cnt_ff + 24'h000001;
        end
    end

    assign blank_o = blank_ff;
    assign live    = disp_on_ff & ~blank_ff;

    // Outputs blank and scan stops when the display is off or starved [R6] [R17]
    assign grid_o    = live ? {grid_b_ff, grid_a_ff} : 9'h000;
    assign anode_a_o = live ? anode_a_ff : 8'h00;
    assign anode_b_o = live ? anode_b_ff : 8'h00;
    assign anode_c_o = live ? anode_c_ff : 8'h00;
    assign anode_d_o = live ? anode_d_ff : 8'h00;

    // Open-drain inverters pull a column low while its digit strobe is high [R8] [R7]
    assign key_col_o      = 8'h00;
    assign key_col_oe_n_o = ~(grid_a_ff & {8{live}}); // [R17]

    // Rear inputs are static; one scan strobe gates them into key requests [R15] [R16]
    assign scan    = live & grid_a_ff[`FPSK_SCAN_BIT];
    assign req     = ~stat_n[4:2] & {3{scan}};
    // Clear/local stays visible with the display off [R18]
    assign clr_key = ~stat_n[1];

    // Standby follows the power switch directly [R19]
    assign standby_o     = ~stat_n[0];
    assign standby_led_o = ~stat_n[0];

    // Refresh tick: count, interrupt cycle, then reset cycle [R20]
    assign tick_last = disp_on_ff ? REFRESH_LAST : REFRESH_OFF_LAST;

    always @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            tick_cnt_ff <= 24'h000000;
            tick_st_ff  <= TK_COUNT;
        end
        else
        begin
            case (tick_st_ff)
                TK_COUNT:
                begin
                    if (tick_cnt_ff >= tick_last)
                    begin
                        tick_cnt_ff <= 24'h000000;
                        tick_st_ff  <= TK_IRQ;
                    end
                    else
                    begin
                        tick_cnt_ff <= tick_cnt_ff + 24'h000001;
                    end
                end
                TK_IRQ:
                begin
                    tick_cnt_ff <= tick_cnt_ff + 24'h000001;
                    tick_st_ff  <= TK_RST;
                end
                TK_RST:
                begin
                    tick_cnt_ff <= tick_cnt_ff + 24'h000001;
                    tick_st_ff  <= TK_COUNT;
                end
                default:
                begin
                    tick_cnt_ff <= 24'h000000;
                    tick_st_ff  <= TK_COUNT;
                end
            endcase
        end
    end

    assign refresh_irq_n_o = ~tick_st_ff[1]; // [R20]
    assign refresh_rst_o   = tick_st_ff[2];

    // Row status drives read data only when its register is addressed [R9]
    always @*
    begin
        nxt_rdata = 32'h00000000;
        if (rd_en)
        begin
            if (paddr_i == `FPSK_OFS_GRID_A)
                nxt_rdata[7:0] = grid_a_ff;
            else if (paddr_i == `FPSK_OFS_GRID_B)
                nxt_rdata[0] = grid_b_ff;
            else if (paddr_i == `FPSK_OFS_ANODE_A)
                nxt_rdata[7:0] = anode_a_ff;
            else if (paddr_i == `FPSK_OFS_ANODE_B)
                nxt_rdata[7:0] = anode_b_ff;
            else if (paddr_i == `FPSK_OFS_ANODE_C)
                nxt_rdata[7:0] = anode_c_ff;
            else if (paddr_i == `FPSK_OFS_ANODE_D)
                nxt_rdata[7:0] = anode_d_ff;
            else if (paddr_i == `FPSK_OFS_CTRL)
                nxt_rdata[1:0] = {clear_lvl_ff, disp_on_ff};
            else if (paddr_i == `FPSK_OFS_STATUS)
            begin
                nxt_rdata[`FPSK_ST_IRQ]     = ~turn_irq_n_o;
                nxt_rdata[`FPSK_ST_UP]      = turn_direction_up_o;
                nxt_rdata[`FPSK_ST_BLANK]   = blank_ff;
                nxt_rdata[`FPSK_ST_STANDBY] = ~stat_n[0];
                nxt_rdata[`FPSK_ST_DISP_ON] = disp_on_ff;
            end
            else if (paddr_i == `FPSK_OFS_KEYS)
            begin
                // Rows read high for a closed key on the strobed column [R7]
                nxt_rdata[7:0] = live ? ~row_n : 8'h00;
                nxt_rdata[`FPSK_KEYS_REQ_LSB+2:`FPSK_KEYS_REQ_LSB] = req;
                nxt_rdata[`FPSK_KEYS_CLR] = clr_key; // [R18]
            end
        end
    end

    // Combinational read mux keeps the slave at zero wait states
    always @*
    begin
        prdata_o = nxt_rdata;
    end
endmodule // fpsk_top

// ### logic/fpsk_map.vh
// Register offsets, field positions, reset values and timing counts of the front panel scan and knob block
// Summary of operation
// (R1) Step phase falling while gate phase low: interrupt low, direction high.
// (R2) Step phase rising while gate phase low: interrupt low, direction low.
// (R3) While gate phase high, step phase transitions are ignored.
// (R4) Controller toggles the knob clear after servicing to release the request.
// (R5) Interrupt and direction hold from qualifying edge until knob clear.
// (R6) Retriggerable timeout blanks display when field or segment writes stop.
// (R7) Key matrix is 8 rows by 8 columns, read as row and column.
// (R8) Matrix columns driven by inverted latched digit strobes, in step with refresh.
// (R9) Row status reaches the bus only when its register is selected.
// (R10) Display refreshed as four groups of nine fields.
// (R11) Groups share grid strobes; each group has its own anode latch.
// (R12) Controller gives a bright digit three extra strobes per refresh sequence.
// (R13) Byte-wide display data is captured into one of several latches.
// (R14) Decoded latch selects pick the single latch capturing each byte.
// (R15) Static rear inputs gated by scan strobes into strobed key requests.
// (R16) Remote unit requests by momentarily grounding a rear panel input.
// (R17) Display off stops scan strobes, so all strobed keys go inactive.
// (R18) Clear/local key bypasses matrix and stays readable with display off.
// (R19) Standby output high with indicator lit when power switch closed.
// (R20) Refresh interrupt every 540 us, or 16.3 ms when off, then reset pulse.
`ifndef FPSK_MAP_VH
`define FPSK_MAP_VH

`define FPSK_OFS_GRID_A    8'h00
`define FPSK_OFS_GRID_B    8'h04
`define FPSK_OFS_ANODE_A   8'h08
`define FPSK_OFS_ANODE_B   8'h0c
`define FPSK_OFS_ANODE_C   8'h10
`define FPSK_OFS_ANODE_D   8'h14
`define FPSK_OFS_CTRL      8'h18
`define FPSK_OFS_STATUS    8'h1c
`define FPSK_OFS_KEYS      8'h20

`define FPSK_CTRL_DISP_ON  0
`define FPSK_CTRL_CLEAR    1
`define FPSK_CTRL_RESET    1'b1

`define FPSK_ST_IRQ        0
`define FPSK_ST_UP         1
`define FPSK_ST_BLANK      2
`define FPSK_ST_STANDBY    3
`define FPSK_ST_DISP_ON    4

`define FPSK_KEYS_REQ_LSB  8
`define FPSK_KEYS_CLR      11

`define FPSK_SCAN_BIT      7

`define FPSK_CLK_PERIOD_NS 8
`define FPSK_REFRESH_NS    540000
`define FPSK_REFRESH_OFF_NS 16300000
`define FPSK_BLANK_NS      2000000
`define FPSK_REFRESH_CYC   (`FPSK_REFRESH_NS / `FPSK_CLK_PERIOD_NS)
`define FPSK_REFRESH_OFF_CYC (`FPSK_REFRESH_OFF_NS / `FPSK_CLK_PERIOD_NS)
`define FPSK_BLANK_CYC     (`FPSK_BLANK_NS / `FPSK_CLK_PERIOD_NS)

`endif

// ### logic/fpsk_sync.v
// Two-stage synchroniser for a bus of asynchronous level inputs
`timescale 1ns/1ps
module fpsk_sync #(
    parameter W   = 1,
    parameter RST = 1'b1
) (
    input  wire         mclk_i,
    input  wire         arst_n_i,
    input  wire [W-1:0] async_i,
    output wire [W-1:0] sync_o
);
    reg [W-1:0] meta_ff;
    reg [W-1:0] sync_ff;

    always @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            meta_ff <= {W{RST}};
            sync_ff <= {W{RST}};
        end
        else
        begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
        end
    end

    assign sync_o = sync_ff;
endmodule // fpsk_sync

// ### logic/fpsk_knob.v
// Edit knob quadrature decoder holding one request until cleared
`timescale 1ns/1ps
module fpsk_knob (
    input  wire mclk_i,
    input  wire arst_n_i,
    input  wire gate_n_i,
    input  wire step_n_i,
    input  wire clear_i,
    output wire turn_irq_n_o,
    output wire turn_direction_up_o
);
    reg  step_d_ff;
    reg  pend_ff;
    reg  up_ff;
    wire fall;
    wire rise;
    wire hit;

    assign fall = step_d_ff & ~step_n_i;
    assign rise = ~step_d_ff & step_n_i;
    // Edges only count while the gate phase is low [R3]
    assign hit  = ~gate_n_i & (fall | rise) & (~pend_ff | clear_i);

    always @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            step_d_ff <= 1'b1;
            pend_ff   <= 1'b0;
            up_ff     <= 1'b0;
        end
        else
        begin
            step_d_ff <= step_n_i;
            // A new edge in the clearing cycle wins over the clear
            if (hit)
            begin
                pend_ff <= 1'b1;
                up_ff   <= fall; // [R1] [R2]
            end
            else if (clear_i)
            begin
                pend_ff <= 1'b0; // [R4]
            end
        end
    end

    // Held until cleared; later edges are dropped so direction stays stable [R5]
    assign turn_irq_n_o        = ~pend_ff;
    assign turn_direction_up_o = up_ff;
endmodule // fpsk_knob

// ### bench/fpsk_monitor.sv
// Checker of knob, blanking, column scan, latch select and refresh timing
`timescale 1ns/1ps
`include "fpsk_map.vh"
module fpsk_monitor #(
    parameter REFRESH_CYC     = 20,
    parameter REFRESH_OFF_CYC = 40,
    parameter BLANK_CYC       = 50
) (
    input wire       mclk_i,
    input wire       arst_n_i,
    input wire       psel_i,
    input wire       penable_i,
    input wire       pwrite_i,
    input wire [7:0] paddr_i,
    input wire       knob_gate_phase_n_i,
    input wire       knob_step_phase_n_i,
    input wire       turn_irq_n_o,
    input wire       turn_direction_up_o,
    input wire [7:0] key_col_oe_n_o,
    input wire [8:0] grid_o,
    input wire       grid_latch_sel_a_n_o,
    input wire       blank_o,
    input wire       refresh_irq_n_o,
    input wire       refresh_rst_o
);
    wire        wr_ev   = psel_i & penable_i & pwrite_i;
    wire        ctrl_wr = wr_ev & (paddr_i == `FPSK_OFS_CTRL);
    wire        lat_wr  = wr_ev & (paddr_i <= `FPSK_OFS_ANODE_D);
    reg         gate_q_ff;
    reg  [2:0]  gate_run_ff;
    reg  [31:0] idle_ff;
    reg  [31:0] gap_ff;
    wire        armed   = turn_irq_n_o & ~knob_gate_phase_n_i & (gate_run_ff >= 3'h4);

    default clocking @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);

    // Idle count starts saturated, so the blanked state out of reset is expected
    always @(posedge mclk_i or negedge arst_n_i)
        if (!arst_n_i)
        begin
            gate_q_ff   <= 1'b1;
            gate_run_ff <= 3'h0;
            idle_ff     <= BLANK_CYC + 8;
            gap_ff      <= 32'h0;
        end
        else
        begin
            gate_q_ff   <= knob_gate_phase_n_i;
            gate_run_ff <= (knob_gate_phase_n_i != gate_q_ff) ? 3'h0 : gate_run_ff + {2'h0, gate_run_ff != 3'h7};
            idle_ff     <= lat_wr ? 32'h0 : idle_ff + {31'h0, idle_ff < BLANK_CYC + 8};
            gap_ff      <= !refresh_irq_n_o ? 32'h1 : gap_ff + {31'h0, gap_ff != 32'h0};
        end

    sequence s_up_req;
        ##[2:5] (!turn_irq_n_o && turn_direction_up_o);
    endsequence
    sequence s_down_req;
        ##[2:5] (!turn_irq_n_o && !turn_direction_up_o);
    endsequence
    sequence s_sel_pulse;
        !grid_latch_sel_a_n_o ##1 grid_latch_sel_a_n_o;
    endsequence

    knob_up_a: assert property (armed && $fell(knob_step_phase_n_i) |-> s_up_req)
        else $error("knob up request missing");
    knob_down_a: assert property (armed && $rose(knob_step_phase_n_i) |-> s_down_req)
        else $error("knob down request missing");
    gate_ignore_a: assert property (
        knob_gate_phase_n_i && gate_run_ff >= 3'h5 && turn_irq_n_o |=> turn_irq_n_o)
        else $error("knob request while gate high");
    irq_hold_a: assert property (
        $rose(turn_irq_n_o) |-> $past(ctrl_wr) || $past(ctrl_wr, 2) || $past(ctrl_wr, 3))
        else $error("knob request released without clear");
    dir_hold_a: assert property (!turn_irq_n_o && !$past(turn_irq_n_o) |-> $stable(turn_direction_up_o))
        else $error("direction moved while pending");
    blank_off_a: assert property (idle_ff >= 2 && idle_ff <= BLANK_CYC - 3 |-> !blank_o)
        else $error("display blanked too early");
    blank_on_a: assert property (idle_ff >= BLANK_CYC + 3 |-> blank_o)
        else $error("display not blanked");
    col_strobe_a: assert property (key_col_oe_n_o == ~grid_o[7:0])
        else $error("columns not in step with grid");
    sel_pick_a: assert property (wr_ev && paddr_i == `FPSK_OFS_GRID_A |=> s_sel_pulse)
        else $error("grid latch select missing");
    refresh_rst_a: assert property (!refresh_irq_n_o |=> refresh_rst_o && refresh_irq_n_o)
        else $error("reset pulse missing after refresh");
    refresh_gap_a: assert property (
        !refresh_irq_n_o && gap_ff != 32'h0 |-> gap_ff >= REFRESH_CYC && gap_ff <= REFRESH_OFF_CYC)
        else $error("refresh spacing wrong");
endmodule  // fpsk_monitor

bind fpsk_top fpsk_monitor #(
    .REFRESH_CYC(REFRESH_CYC), .REFRESH_OFF_CYC(REFRESH_OFF_CYC), .BLANK_CYC(BLANK_CYC)
) u_mon (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .knob_gate_phase_n_i(knob_gate_phase_n_i), .knob_step_phase_n_i(knob_step_phase_n_i),
    .turn_irq_n_o(turn_irq_n_o), .turn_direction_up_o(turn_direction_up_o), .key_col_oe_n_o(key_col_oe_n_o),
    .grid_o(grid_o), .grid_latch_sel_a_n_o(grid_latch_sel_a_n_o), .blank_o(blank_o),
    .refresh_irq_n_o(refresh_irq_n_o), .refresh_rst_o(refresh_rst_o)
);

// ### bench/fpsk_panel_model.sv
// Key matrix model: a closed contact ties its row to its column
`timescale 1ns/1ps
module fpsk_panel_model (
    input  logic [7:0]  col_oe_n_i,
    input  logic [63:0] pressed_i,
    output logic [7:0]  row_n_o
);
    // Rows sit at the pull-up level unless a closed contact meets a column pulled low
    always_comb
        for (int r = 0; r < 8; r++)
            row_n_o[r] = ~|(pressed_i[r*8 +: 8] & ~col_oe_n_i);
endmodule  // fpsk_panel_model

// ### bench/fpsk_top_bench.sv
// Self-checking bench of the front panel scan and knob block
`timescale 1ns/1ps
`include "fpsk_map.vh"
module fpsk_top_bench;
    localparam RC = 20, RO = 40, BLK = 50;
    logic        mclk_i = 1'b0, arst_n_i = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00, ctrl = 8'h01;
    logic [31:0] pwdata = 32'h0, prdata, rdata;
    logic        gate_n = 1'b1, step_n = 1'b1, up_n = 1'b1, dn_n = 1'b1, br_n = 1'b1, cl_n = 1'b1, sw = 1'b1;
    logic [63:0] pressed = 64'h0;
    logic [7:0]  row_n, col, col_oe_n, an_a, an_b, an_c, an_d;
    logic [8:0]  grid;
    logic        irq_n, dir_up, blank, rirq_n, rrst, stby, stby_led, pready, pslverr, rerr;
    int          fail_count = 0, tests_run = 0, cyc = 0;

    always #4 mclk_i = ~mclk_i;

    fpsk_top #(.REFRESH_CYC(RC), .REFRESH_OFF_CYC(RO), .BLANK_CYC(BLK)) uut (
        .mclk_i(mclk_i), .arst_n_i(arst_n_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .knob_gate_phase_n_i(gate_n), .knob_step_phase_n_i(step_n), .turn_irq_n_o(irq_n),
        .turn_direction_up_o(dir_up), .key_row_n_i(row_n), .key_col_o(col), .key_col_oe_n_o(col_oe_n),
        .seq_up_n_i(up_n), .seq_down_n_i(dn_n), .bright_sel_n_i(br_n), .clear_local_key_n_i(cl_n),
        .standby_sw_closed_i(sw), .standby_o(stby), .standby_led_o(stby_led), .grid_o(grid),
        .anode_a_o(an_a), .anode_b_o(an_b), .anode_c_o(an_c), .anode_d_o(an_d),
        .grid_latch_sel_a_n_o(), .grid_latch_sel_b_n_o(), .anode_latch_sel_a_n_o(),
        .anode_latch_sel_b_n_o(), .anode_latch_sel_c_n_o(), .anode_latch_sel_d_n_o(),
        .blank_o(blank), .refresh_irq_n_o(rirq_n), .refresh_rst_o(rrst)
    );

    fpsk_panel_model u_panel (.col_oe_n_i(col_oe_n), .pressed_i(pressed), .row_n_o(row_n));

    task stop_test;
        $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task wt(input int n);
        repeat (n) @(posedge mclk_i);
    endtask

    // Zero-wait slave, but the loop still honours pready in case that ever changes
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk_i);
        penable <= 1'b1;
        do @(posedge mclk_i); while (pready !== 1'b1);
        rdata   = prdata;
        rerr    = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task t_reset;
        apb(1'b1, 8'h24, 32'hff);
        chk({31'h0, rerr}, 32'h1);
        apb(1'b1, `FPSK_OFS_STATUS, 32'hff);
        apb(1'b0, `FPSK_OFS_STATUS, 32'h0);
        chk(rdata, 32'h1c);
    endtask

    task t_latch;
        logic [7:0] v [6] = '{8'ha5, 8'h01, 8'h3c, 8'hc3, 8'h5a, 8'h96};
        for (int i = 0; i < 6; i++)
            apb(1'b1, 8'(i * 4), {24'hffffff, v[i]});
        wt(2);
        chk({7'h0, grid, an_a, an_b}, 32'h1a53cc3);
        chk({16'h0, an_c, an_d}, 32'h5a96);
    endtask

    task keys(input logic [7:0] g, input logic [31:0] exp);
        apb(1'b1, `FPSK_OFS_GRID_A, {24'h0, g});
        wt(4);
        apb(1'b0, `FPSK_OFS_KEYS, 32'h0);
        chk(rdata, exp);
    endtask

    task t_keys;
        pressed <= 64'h0000_0800_0000_0080;
        up_n    <= 1'b0;
        br_n    <= 1'b0;
        cl_n    <= 1'b0;
        keys(8'h08, 32'h820);
        chk({24'h0, col_oe_n}, 32'hf7);
        chk({24'h0, col}, 32'h0);
        keys(8'h80, 32'hd01);
        apb(1'b1, `FPSK_OFS_CTRL, 32'h0);
        keys(8'h80, 32'h800);
        chk({23'h0, grid}, 32'h0);
        apb(1'b1, `FPSK_OFS_CTRL, {24'h0, ctrl});
        up_n    <= 1'b1;
        br_n    <= 1'b1;
        cl_n    <= 1'b1;
    endtask

    task turn(input logic g, input logic s, input logic [1:0] exp);
        gate_n <= g;
        step_n <= s;
        wt(8);
        chk({30'h0, irq_n, dir_up}, {30'h0, exp});
    endtask

    task clr;
        ctrl = ctrl ^ 8'h02;
        apb(1'b1, `FPSK_OFS_CTRL, {24'h0, ctrl});
        wt(3);
        chk({31'h0, irq_n}, 32'h1);
    endtask

    task t_knob;
        turn(1'b0, 1'b1, 2'b10);
        turn(1'b0, 1'b0, 2'b01);
        apb(1'b0, `FPSK_OFS_STATUS, 32'h0);
        chk({30'h0, rdata[1:0]}, 32'h3);
        clr;
        turn(1'b0, 1'b1, 2'b00);
        turn(1'b0, 1'b0, 2'b00);
        clr;
        turn(1'b1, 1'b0, 2'b10);
        turn(1'b1, 1'b1, 2'b10);
        turn(1'b1, 1'b0, 2'b10);
        turn(1'b0, 1'b0, 2'b10);
    endtask

    task t_blank;
        apb(1'b1, `FPSK_OFS_GRID_A, 32'h11);
        wt(BLK - 8);
        chk({31'h0, blank}, 32'h0);
        wt(16);
        chk({22'h0, blank, grid}, 32'h200);
        apb(1'b1, `FPSK_OFS_ANODE_B, 32'h7e);
        repeat (3) apb(1'b1, `FPSK_OFS_GRID_A, 32'h11);
        wt(2);
        chk({22'h0, blank, grid}, 32'h111);
    endtask

    task period(output logic [31:0] p);
        time t0;
        @(posedge mclk_i iff rirq_n === 1'b0);
        t0 = $time;
        @(posedge mclk_i iff rirq_n === 1'b0);
        p = 32'(($time - t0) / 8);
    endtask

    task t_refresh;
        logic [31:0] p;
        period(p);
        chk(p, RC);
        apb(1'b1, `FPSK_OFS_CTRL, 32'h0);
        period(p);
        period(p);
        chk(p, RO);
        apb(1'b1, `FPSK_OFS_CTRL, {24'h0, ctrl});
    endtask

    task t_standby;
        sw <= 1'b0;
        wt(4);
        chk({30'h0, stby, stby_led}, 32'h0);
        sw <= 1'b1;
        wt(4);
        chk({30'h0, stby, stby_led}, 32'h3);
    endtask

    // Hang guard: the whole sequence needs well under two thousand cycles
    always @(posedge mclk_i)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            fail_count++;
            stop_test;
        end
    end

    initial
    begin
        wt(8);
        arst_n_i <= 1'b1;
        t_reset;
        t_latch;
        t_keys;
        t_knob;
        t_blank;
        t_refresh;
        t_standby;
        stop_test;
    end
endmodule  // fpsk_top_bench
